// ===== core/pcr_config_bank.sv
// configuration bank: thresholds, power button handling, io rail good monitor
// assumes all inputs are synchronous to MCLK_IN; the serial port front end
// drives the byte register port
//
// What this block does
// - high-current warning code 01/10/11 selects 5/5.5/6 A; default 11.
// - undervoltage power-down code 01/10/11 trips at 2.7/3.0/4.25 V; default 01.
// - button mode bit: 0 on/off switch, 1 long-press button; default 1.
// - coin cell termination is 1.8 V plus 0.1 V per code; default 1111.
// - hold period code 00..11 means 1, 1.5, 2, 3 s; default 00.
// - io good timeout code 00 none, 01 0.5 ms, 10 1 ms; default 10.
// - io good before timer expiry moves the sequencer to standby.
// - io good still low at expiry moves the sequencer to fault exit.
`timescale 1ns/100ps
module pcr_config_bank #(
  parameter int HOLD_UNIT_CYC = pcr_pkg::CLK_HZ / 1000 * pcr_pkg::HOLD_UNIT_MS,
  parameter int IO_UNIT_CYC = pcr_pkg::CLK_HZ / 1_000_000 * pcr_pkg::IO_UNIT_US,
  parameter logic BUTTON_ACTIVE_LEVEL = 1'b1
) (
  input wire logic MCLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  input wire logic POWER_BUTTON_INPUT_IN,
  input wire logic IO_MON_START_IN,
  input wire logic IO_RAIL_POWER_GOOD_IN,
  output logic [12:0] HICUR_WARN_MA_OUT,
  output logic [12:0] SUPPLY_UNDERVOLTAGE_POWERDOWN_LEVEL_OUT,
  output logic [11:0] COIN_CELL_TERM_VOLTAGE_OUT,
  output logic POWER_BUTTON_ON_OUT,
  output logic POWER_BUTTON_PRESS_OUT,
  output logic IO_STANDBY_REQ_OUT,
  output logic IO_FAULT_REQ_OUT
);
  logic [7:0] cfg1_q, cfg1_d, cfg2_q, cfg2_d, cfg3_q, cfg3_d;
  logic [7:0] rdata_q, rdata_d;
  logic [12:0] hicur_q, hicur_d, uvpd_q, uvpd_d;
  logic [11:0] term_q, term_d;
  logic on_q, on_d, press_q, press_d, armed_q, armed_d;
  logic stb_q, stb_d, flt_q, flt_d;
  pcr_pkg::pcr_io_state_t io_q, io_d;
  logic [1:0] hicur_code, uvpd_code, hold_code, io_code;
  logic [3:0] term_code;
  logic mode_push, btn_act;
  logic [31:0] hold_lim, hold_cnt, io_lim, io_cnt;
  logic hold_exp, io_exp, io_exp_ok;

  // field extraction
  assign hicur_code = cfg1_q[pcr_pkg::HICUR_LSB +: 2];
  assign uvpd_code = cfg1_q[pcr_pkg::UVPD_LSB +: 2];
  assign mode_push = cfg1_q[pcr_pkg::MODE_BIT];
  assign term_code = cfg2_q[pcr_pkg::TERM_LSB +: 4];
  assign hold_code = cfg2_q[pcr_pkg::HOLD_LSB +: 2];
  assign io_code = cfg3_q[pcr_pkg::IOTO_LSB +: 2];
  assign btn_act = (POWER_BUTTON_INPUT_IN == BUTTON_ACTIVE_LEVEL);

  // register writes and reads; CFG2 and CFG3 bits outside their masks keep fixed values, CFG1 is written whole
  always_comb begin
    cfg1_d = cfg1_q;
    cfg2_d = cfg2_q;
    cfg3_d = cfg3_q;
    rdata_d = rdata_q;
    if (REG_WR_IN) begin
      if (REG_ADDR_IN == pcr_pkg::OFS_CFG1) begin
        cfg1_d = REG_WDATA_IN;
      end else if (REG_ADDR_IN == pcr_pkg::OFS_CFG2) begin
        cfg2_d = (REG_WDATA_IN & pcr_pkg::MASK_CFG2) | (pcr_pkg::RST_CFG2 & ~pcr_pkg::MASK_CFG2);
      end else if (REG_ADDR_IN == pcr_pkg::OFS_CFG3) begin
        cfg3_d = REG_WDATA_IN & pcr_pkg::MASK_CFG3;
      end
    end
    if (REG_RD_IN) begin
      if (REG_ADDR_IN == pcr_pkg::OFS_CFG1) begin
        rdata_d = cfg1_q;
      end else if (REG_ADDR_IN == pcr_pkg::OFS_CFG2) begin
        rdata_d = cfg2_q;
      end else if (REG_ADDR_IN == pcr_pkg::OFS_CFG3) begin
        rdata_d = cfg3_q;
      end else if (REG_ADDR_IN == pcr_pkg::OFS_STATUS) begin
        rdata_d = {2'b00, press_q, on_q, io_q};
      end else begin
        rdata_d = 8'h00; // unmapped reads return zero
      end
    end
  end

  // defaults load at reset
  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      cfg1_q <= pcr_pkg::RST_CFG1;
      cfg2_q <= pcr_pkg::RST_CFG2;
      cfg3_q <= pcr_pkg::RST_CFG3;
      rdata_q <= 8'h00;
    end else begin
      cfg1_q <= cfg1_d;
      cfg2_q <= cfg2_d;
      cfg3_q <= cfg3_d;
      rdata_q <= rdata_d;
    end
  end
  assign REG_RDATA_OUT = rdata_q;

  // threshold decode for the analog trims; code 00 is undefined, shown as 0
  always_comb begin
    case (hicur_code)
      2'b01: hicur_d = pcr_pkg::HICUR_MA_1;
      2'b10: hicur_d = pcr_pkg::HICUR_MA_2;
      2'b11: hicur_d = pcr_pkg::HICUR_MA_3;
      default: hicur_d = 13'h0000;
    endcase
    case (uvpd_code)
      2'b01: uvpd_d = pcr_pkg::UVPD_MV_1;
      2'b10: uvpd_d = pcr_pkg::UVPD_MV_2;
      2'b11: uvpd_d = pcr_pkg::UVPD_MV_3;
      default: uvpd_d = 13'h0000;
    endcase
    term_d = pcr_pkg::TERM_BASE_MV + 12'(pcr_pkg::TERM_STEP_MV * {8'h00, term_code});
  end

  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      hicur_q <= 13'h0000;
      uvpd_q <= 13'h0000;
      term_q <= 12'h000;
    end else begin
      hicur_q <= hicur_d;
      uvpd_q <= uvpd_d;
      term_q <= term_d;
    end
  end
  assign HICUR_WARN_MA_OUT = hicur_q;
  assign SUPPLY_UNDERVOLTAGE_POWERDOWN_LEVEL_OUT = uvpd_q;
  assign COIN_CELL_TERM_VOLTAGE_OUT = term_q;

  // hold period select, in 0.5 s units
  always_comb begin
    case (hold_code)
      2'b00: hold_lim = 32'(pcr_pkg::HOLD_MULT_0 * HOLD_UNIT_CYC);
      2'b01: hold_lim = 32'(pcr_pkg::HOLD_MULT_1 * HOLD_UNIT_CYC);
      2'b10: hold_lim = 32'(pcr_pkg::HOLD_MULT_2 * HOLD_UNIT_CYC);
      default: hold_lim = 32'(pcr_pkg::HOLD_MULT_3 * HOLD_UNIT_CYC);
    endcase
  end

  // hold timer restarts the moment the button leaves its active level
  pcr_timer #(.W(32)) u_hold_timer (
    .clk_in(MCLK_IN),
    .rst_in(SYS_RST_IN),
    .restart_in(!btn_act),
    .run_in(btn_act),
    .limit_in(hold_lim),
    .count_out(hold_cnt),
    .expired_out(hold_exp)
  );

  // button: direct level in switch mode, toggle per accepted long press
  always_comb begin
    armed_d = armed_q;
    press_d = 1'b0;
    if (!btn_act) begin
      armed_d = 1'b1; // one press event per push, rearmed on release
    end else if (hold_exp && armed_q) begin
      armed_d = 1'b0;
      press_d = mode_push;
    end
    if (mode_push) begin
      on_d = on_q ^ press_d;
    end else begin
      on_d = btn_act;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      armed_q <= 1'b0;
      press_q <= 1'b0;
      on_q <= 1'b0;
    end else begin
      armed_q <= armed_d;
      press_q <= press_d;
      on_q <= on_d;
    end
  end
  assign POWER_BUTTON_ON_OUT = on_q;
  assign POWER_BUTTON_PRESS_OUT = press_q;

  // io good timeout select; code 00 never expires
  always_comb begin
    case (io_code)
      2'b01: io_lim = 32'(pcr_pkg::IO_MULT_1 * IO_UNIT_CYC);
      2'b10: io_lim = 32'(pcr_pkg::IO_MULT_2 * IO_UNIT_CYC);
      2'b11: io_lim = 32'(pcr_pkg::IO_MULT_3 * IO_UNIT_CYC);
      default: io_lim = 32'hFFFF_FFFF;
    endcase
  end

  pcr_timer #(.W(32)) u_io_timer (
    .clk_in(MCLK_IN),
    .rst_in(SYS_RST_IN),
    .restart_in(IO_MON_START_IN),
    .run_in(io_q == pcr_pkg::IO_MON),
    .limit_in(io_lim),
    .count_out(io_cnt),
    .expired_out(io_exp)
  );
  assign io_exp_ok = io_exp && (io_code != 2'b00);

  // io monitor: good seen in the expiry cycle still counts as in time
  always_comb begin
    io_d = io_q;
    stb_d = 1'b0;
    flt_d = 1'b0;
    if (IO_MON_START_IN) begin
      io_d = pcr_pkg::IO_MON;
    end else begin
      case (io_q)
        pcr_pkg::IO_MON: begin
          if (IO_RAIL_POWER_GOOD_IN) begin
            io_d = pcr_pkg::IO_STANDBY;
            stb_d = 1'b1;
          end else if (io_exp_ok) begin
            io_d = pcr_pkg::IO_FAULT;
            flt_d = 1'b1;
          end
        end
        default: io_d = io_q;
      endcase
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      io_q <= pcr_pkg::IO_IDLE;
      stb_q <= 1'b0;
      flt_q <= 1'b0;
    end else begin
      io_q <= io_d;
      stb_q <= stb_d;
      flt_q <= flt_d;
    end
  end
  assign IO_STANDBY_REQ_OUT = stb_q;
  assign IO_FAULT_REQ_OUT = flt_q;

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  property p_hicur; (hicur_code == 2'b10) |=> (HICUR_WARN_MA_OUT == 13'h157C); endproperty
  a_hicur: assert property (p_hicur) else $error("warning threshold not 5.5 A");
  property p_uvpd; (uvpd_code == 2'b11) |=> (SUPPLY_UNDERVOLTAGE_POWERDOWN_LEVEL_OUT == 13'h109A);
  endproperty
  a_uvpd: assert property (p_uvpd) else $error("undervoltage level not 4.25 V");
  property p_switch; !mode_push |=> (POWER_BUTTON_ON_OUT == $past(btn_act)); endproperty
  a_switch: assert property (p_switch) else $error("switch mode level not followed");
  property p_term;
    1'b1 |=> (COIN_CELL_TERM_VOLTAGE_OUT == 12'(12'h708 + 12'h064 * $past(term_code)));
  endproperty
  a_term: assert property (p_term) else $error("termination voltage wrong");
  property p_hold; (mode_push && btn_act && armed_q && hold_cnt == hold_lim)
    |=> POWER_BUTTON_PRESS_OUT;
  endproperty
  a_hold: assert property (p_hold) else $error("long press not accepted at hold end");
  property p_noearly; POWER_BUTTON_PRESS_OUT |-> ($past(hold_cnt) == $past(hold_lim));
  endproperty
  a_noearly: assert property (p_noearly) else $error("press accepted before hold end");
  property p_restart; !btn_act |=> (hold_cnt == 32'h0000_0000); endproperty
  a_restart: assert property (p_restart) else $error("hold count not restarted");
  property p_indef; (io_q == pcr_pkg::IO_MON && io_code == 2'b00) |=> !IO_FAULT_REQ_OUT;
  endproperty
  a_indef: assert property (p_indef) else $error("fault with indefinite timeout");
  property p_stby; (io_q == pcr_pkg::IO_MON && IO_RAIL_POWER_GOOD_IN && !IO_MON_START_IN)
    |=> (IO_STANDBY_REQ_OUT && io_q == pcr_pkg::IO_STANDBY); endproperty
  a_stby: assert property (p_stby) else $error("no standby on io good");
  property p_fault; (io_q == pcr_pkg::IO_MON && io_exp && io_code != 2'b00
    && !IO_RAIL_POWER_GOOD_IN && !IO_MON_START_IN)
    |=> (IO_FAULT_REQ_OUT && io_q == pcr_pkg::IO_FAULT);
  endproperty
  a_fault: assert property (p_fault) else $error("no fault exit at expiry");
  // a start must clear the timer, otherwise a stale count would fault early
  property p_iostart; IO_MON_START_IN |=> (io_cnt == 32'h0000_0000 && io_q == pcr_pkg::IO_MON);
  endproperty
  a_iostart: assert property (p_iostart) else $error("monitor not restarted");
endmodule // pcr_config_bank

// ===== common/pcr_pkg.sv
// shared constants for the power configuration register bank
// assumes a single 25 MHz clock and a byte-wide internal register port
package pcr_pkg;
  // register offsets on the byte register port
  localparam logic [7:0] OFS_CFG1 = 8'h00;
  localparam logic [7:0] OFS_CFG2 = 8'h01;
  localparam logic [7:0] OFS_CFG3 = 8'h02;
  localparam logic [7:0] OFS_STATUS = 8'h03;
  // reset values
  localparam logic [7:0] RST_CFG1 = 8'hFB;
  localparam logic [7:0] RST_CFG2 = 8'hF8;
  localparam logic [7:0] RST_CFG3 = 8'h17;
  // writable masks; masked-off bits read back their fixed value
  localparam logic [7:0] MASK_CFG2 = 8'hF3;
  localparam logic [7:0] MASK_CFG3 = 8'h1F;
  // field positions
  localparam int HICUR_LSB = 3;
  localparam int UVPD_LSB = 1;
  localparam int MODE_BIT = 0;
  localparam int TERM_LSB = 4;
  localparam int HOLD_LSB = 0;
  localparam int IOTO_LSB = 3;
  // threshold values in mA and mV
  localparam logic [12:0] HICUR_MA_1 = 13'h1388;
  localparam logic [12:0] HICUR_MA_2 = 13'h157C;
  localparam logic [12:0] HICUR_MA_3 = 13'h1770;
  localparam logic [12:0] UVPD_MV_1 = 13'h0A8C;
  localparam logic [12:0] UVPD_MV_2 = 13'h0BB8;
  localparam logic [12:0] UVPD_MV_3 = 13'h109A;
  localparam logic [11:0] TERM_BASE_MV = 12'h708;
  localparam logic [11:0] TERM_STEP_MV = 12'h064;
  // timing
  localparam int CLK_HZ = 25_000_000;
  localparam int HOLD_UNIT_MS = 500;
  localparam int IO_UNIT_US = 500;
  localparam int HOLD_MULT_0 = 2;
  localparam int HOLD_MULT_1 = 3;
  localparam int HOLD_MULT_2 = 4;
  localparam int HOLD_MULT_3 = 6;
  localparam int IO_MULT_1 = 1;
  localparam int IO_MULT_2 = 2;
  localparam int IO_MULT_3 = 4;
  // io rail monitor states
  typedef enum logic [3:0] {
    IO_IDLE = 4'h1,
    IO_MON = 4'h2,
    IO_STANDBY = 4'h4,
    IO_FAULT = 4'h8
  } pcr_io_state_t;
endpackage

// ===== core/pcr_timer.sv
// restartable up-counter that stops at a programmable limit
// assumes restart and run are synchronous to clk_in
`timescale 1ns/100ps
module pcr_timer #(
  parameter int W = 32
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic restart_in,
  input wire logic run_in,
  input wire logic [W-1:0] limit_in,
  output logic [W-1:0] count_out,
  output logic expired_out
);
  logic [W-1:0] count_q;
  logic [W-1:0] count_d;

  // saturate at the limit so a held input cannot wrap and fire twice
  always_comb begin
    count_d = count_q;
    if (restart_in) begin
      count_d = '0;
    end else if (run_in && (count_q < limit_in)) begin
      count_d = count_q + 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign count_out = count_q;
  assign expired_out = (count_q >= limit_in);
endmodule // pcr_timer

// ===== verif/pcr_config_bank_tb.sv
// self-checking bench for the power configuration register bank
// assumes short timing units so that hold and io timeouts run in a few cycles
`timescale 1ns/100ps
module pcr_config_bank_tb;
  localparam int HU = 4;
  localparam int IU = 3;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic btn = 1'b0;
  logic start = 1'b0;
  logic good = 1'b0;
  logic [7:0] rdata;
  logic [12:0] hicur;
  logic [12:0] uvpd;
  logic [11:0] term;
  logic on;
  logic press;
  logic sb;
  logic ft;
  int fails = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'h0EF73123;
  logic [7:0] d;
  logic prev;
  int f1;
  int f2;
  int lim;

  // free-running bench clock, 40 ns period
  always #20 mclk = ~mclk;

  pcr_config_bank #(.HOLD_UNIT_CYC(HU), .IO_UNIT_CYC(IU)) dut_u (
    .MCLK_IN(mclk), .SYS_RST_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .POWER_BUTTON_INPUT_IN(btn),
    .IO_MON_START_IN(start), .IO_RAIL_POWER_GOOD_IN(good), .HICUR_WARN_MA_OUT(hicur),
    .SUPPLY_UNDERVOLTAGE_POWERDOWN_LEVEL_OUT(uvpd), .COIN_CELL_TERM_VOLTAGE_OUT(term),
    .POWER_BUTTON_ON_OUT(on), .POWER_BUTTON_PRESS_OUT(press),
    .IO_STANDBY_REQ_OUT(sb), .IO_FAULT_REQ_OUT(ft)
  );

  // galois shift register, fixed seed keeps runs repeatable
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  function automatic logic [12:0] hicur_ma(input logic [1:0] c);
    return (c == 2'h1) ? 13'h1388 : (c == 2'h2) ? 13'h157C : (c == 2'h3) ? 13'h1770 : 13'h0000;
  endfunction

  function automatic logic [12:0] uvpd_mv(input logic [1:0] c);
    return (c == 2'h1) ? 13'h0A8C : (c == 2'h2) ? 13'h0BB8 : (c == 2'h3) ? 13'h109A : 13'h0000;
  endfunction

  // hold limit in cycles: 1, 1.5, 2, 3 s as multiples of a half-second unit
  function automatic int hold_limit(input logic [1:0] c);
    return HU * ((c == 2'h0) ? 2 : (c == 2'h1) ? 3 : (c == 2'h2) ? 4 : 6);
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD at %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    addr = a;
    wdata = v;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
  endtask

  // read data is taken after a further edge, it then holds
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    addr = a;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    tick(1);
    v = rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd_reg(a, v);
    chk({8'h00, v}, {8'h00, e});
  endtask

  // hold the button for len cycles, note first press pulse and pulse count
  task automatic hold_btn(input int len, output int first, output int cnt);
    first = -1;
    cnt = 0;
    btn = 1'b1;
    for (int k = 0; k < len + 4; k++) begin
      if (k == len) btn = 1'b0;
      tick(1);
      if (press === 1'b1) begin
        cnt++;
        if (first < 0) first = k;
      end
    end
  endtask

  // start monitoring, raise good at cycle ga (none if negative)
  task automatic io_run(input int ga, output int fsb, output int fft);
    fsb = -1;
    fft = -1;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    for (int k = 0; k < 40; k++) begin
      if (k == ga) good = 1'b1;
      tick(1);
      if (sb === 1'b1 && fsb < 0) fsb = k;
      if (ft === 1'b1 && fft < 0) fft = k;
    end
    good = 1'b0;
  endtask

  // watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(negedge mclk);
    fails++;
    finish_test();
  end

  // main sequence
  initial begin
    tick(2);
    rst = 1'b0;
    tick(1);
    rd_chk(8'h00, 8'hFB);
    rd_chk(8'h01, 8'hF8);
    rd_chk(8'h02, 8'h17);
    chk({3'h0, hicur}, 16'h1770);
    chk({3'h0, uvpd}, 16'h0A8C);
    chk({4'h0, term}, 16'h0CE4);
    // every current and undervoltage code, random other bits, push mode kept
    for (int i = 0; i < 16; i++) begin
      seed = lfsr_next(seed);
      d = {seed[7:5], i[3:0], 1'b1};
      wr_reg(8'h00, d);
      tick(2);
      chk({3'h0, hicur}, {3'h0, hicur_ma(d[4:3])});
      chk({3'h0, uvpd}, {3'h0, uvpd_mv(d[2:1])});
      rd_chk(8'h00, d);
    end
    // all termination codes; reserved bits read back fixed
    for (int i = 0; i < 16; i++) begin
      seed = lfsr_next(seed);
      d = {i[3:0], seed[3:0]};
      wr_reg(8'h01, d);
      tick(2);
      chk({4'h0, term}, 16'h0708 + 16'h0064 * i[15:0]);
      rd_chk(8'h01, (d & 8'hF3) | 8'h08);
    end
    seed = lfsr_next(seed);
    wr_reg(8'h02, seed[7:0]);
    rd_chk(8'h02, seed[7:0] & 8'h1F);
    wr_reg(8'h04 + {1'b0, seed[14:8]}, 8'h00);
    rd_chk(8'h02, seed[7:0] & 8'h1F);
    // long press: short and interrupted holds give nothing, full hold one pulse
    for (int c = 0; c < 4; c++) begin
      wr_reg(8'h01, {6'h3E, c[1:0]});
      lim = hold_limit(c[1:0]);
      prev = on;
      hold_btn(lim - 2, f1, f2);
      chk(f2[15:0], 16'h0000);
      hold_btn(lim - 2, f1, f2);
      chk(f2[15:0], 16'h0000);
      hold_btn(lim + 4, f1, f2);
      chk(f2[15:0], 16'h0001);
      chk({15'h0, f1 >= lim && f1 <= lim + 3}, 16'h0001);
      chk({15'h0, on}, {15'h0, ~prev});
    end
    // switch mode: on follows the button one cycle later, no press pulses
    wr_reg(8'h00, 8'hFA);
    tick(2);
    for (int k = 0; k < 20; k++) begin
      seed = lfsr_next(seed);
      prev = btn;
      btn = seed[0];
      tick(1);
      chk({14'h0, on, press}, {14'h0, btn, 1'b0});
    end
    btn = 1'b0;
    // io good monitor for every timeout code
    for (int c = 0; c < 4; c++) begin
      wr_reg(8'h02, {3'h0, c[1:0], 3'h7});
      lim = IU * ((c == 1) ? 1 : (c == 2) ? 2 : 4);
      io_run(-1, f1, f2);
      if (c == 0) chk(f2[15:0], 16'hFFFF);
      else chk({15'h0, f2 >= lim && f2 <= lim + 3}, 16'h0001);
      rd_chk(8'h03, (c == 0) ? 8'h02 : 8'h08);
      io_run((c == 0) ? 30 : lim - 2, f1, f2);
      chk(f2[15:0], 16'hFFFF);
      chk({15'h0, f1 >= 0 && f1 <= ((c == 0) ? 33 : lim + 1)}, 16'h0001);
      rd_chk(8'h03, 8'h04);
    end
    // mid-run reset restores defaults
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(1);
    rd_chk(8'h00, 8'hFB);
    rd_chk(8'h01, 8'hF8);
    rd_chk(8'h02, 8'h17);
    rd_chk(8'h03, 8'h01);
    chk({3'h0, hicur}, 16'h1770);
    chk({3'h0, uvpd}, 16'h0A8C);
    chk({4'h0, term}, 16'h0CE4);
    finish_test();
  end
endmodule // pcr_config_bank_tb
